// ### hw/clock_fault_pkg.sv
// types shared by the clock input fault monitor
package clock_fault_pkg;
  typedef enum logic [2:0] {REF_EXTERNAL, REF_IN0, REF_IN1, REF_IN2, REF_CRYSTAL} zero_ppm_src_t;
  typedef struct packed {
    logic        switched;
    logic [16:0] freq_err;
  } loop_report_t;
  typedef struct packed {
    logic       lol_pps;
    logic [2:0] lol_std;
    logic [3:0] frequency_out_of_range_flag;
    logic [4:0] signal_loss_flag;
  } status_t;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;
endpackage

// ### hw/clock_fault_regs.svh
// register offsets, field positions and reset values of the clock input fault monitor
`ifndef CLOCK_FAULT_REGS_SVH
`define CLOCK_FAULT_REGS_SVH
`define REG_CTRL          8'h00
`define REG_LOS_LIMIT0    8'h10
`define REG_OOF_WINDOW    8'h24
`define REG_OOF_HYST      8'h28
`define REG_PREC_GATE     8'h2C
`define REG_PREC_NOM      8'h30
`define REG_FAST_GATE     8'h34
`define REG_FAST_NOM      8'h38
`define REG_LOL_SET0      8'h40
`define REG_LOL_CLR0      8'h50
`define REG_LOL_DELAY     8'h5C
`define REG_PPS_TRIG_THR  8'h60
`define REG_PPS_CLR_THR   8'h64
`define REG_PPS_TRIG_CNT  8'h68
`define REG_PPS_CLR_CNT   8'h6C
`define REG_INT_MASK      8'h70
`define REG_LIVE          8'h80
`define REG_STICKY        8'h84
`define CTRL_LOS_DIS_LSB  0
`define CTRL_PREC_DIS     5
`define CTRL_FAST_DIS     6
`define CTRL_KEEP_OUT     7
`define CTRL_REF_SEL_LSB  8
`define CTRL_PPS_MODE     11
`define CTRL_RST          12'h000
`define LOS_LIMIT_RST     16'h0100
`define OOF_WINDOW_RST    13'h0640
`define OOF_HYST_RST      13'h0020
`define PREC_GATE_RST     24'hF42400
`define PREC_NOM_RST      24'hF42400
`define FAST_GATE_RST     16'h03E8
`define FAST_NOM_RST      16'h03E8
`define FAST_PPM_DIV      24'h0000FA
`define LOL_SET_RST       17'h0000A
`define LOL_CLR_RST       17'h00001
`define LOL_DELAY_RST     24'h000000
`define PPS_TRIG_THR_RST  16'h0100
`define PPS_CLR_THR_RST   16'h0040
`define PPS_CNT_RST       16'h0008
`define STATUS_PPS_MASK   13'h1800
`endif

// ### hw/clock_input_fault_monitor.sv
// clock input fault monitor: signal loss, frequency range and lock loss with live and sticky status
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`include "clock_fault_regs.svh"

module clock_input_fault_monitor (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire clock_fault_pkg::reg_req_t     req,
  output logic [31:0]                        rdata,
  input  wire logic [2:0]                    general_clock_inputs,
  input  wire logic                          external_reference_input,
  input  wire logic                          crystal_input_pair,
  input  wire clock_fault_pkg::loop_report_t loop_report [3],
  input  wire logic [15:0]                   pps_phase_err,
  output logic                               lock_lost_pin_loop_a,
  output logic                               lock_lost_pin_loop_c,
  output logic                               lock_lost_pin_loop_d,
  output logic                               lock_lost_pin_n,
  output logic                               interrupt_pin_n,
  output logic                               outputs_enable,
  output logic [2:0]                         input_usable
);
  import clock_fault_pkg::*;

  logic [4:0]  sync1_ff;
  logic [4:0]  sync2_ff;
  logic [4:0]  prev_ff;
  logic [4:0]  edge_seen;
  logic [11:0] ctrl_ff;
  logic [15:0] los_limit_ff [5];
  logic [15:0] per_cnt_ff [5];
  logic [12:0] oof_window_ff;
  logic [12:0] oof_hyst_ff;
  logic [23:0] prec_gate_ff;
  logic [23:0] prec_nom_ff;
  logic [15:0] fast_gate_ff;
  logic [15:0] fast_nom_ff;
  logic [16:0] lol_set_ff [3];
  logic [16:0] lol_clr_ff [3];
  logic [23:0] lol_delay_ff;
  logic [15:0] pps_trig_thr_ff;
  logic [15:0] pps_clr_thr_ff;
  logic [15:0] pps_trig_cnt_ff;
  logic [15:0] pps_clr_cnt_ff;
  logic [12:0] int_mask_ff;
  status_t     live;
  status_t     sticky_ff;
  logic [4:0]  los_ff;
  logic [3:0]  prec_oof_ff;
  logic [3:0]  fast_oof_ff;
  logic [2:0]  lol_std_ff;
  logic        lol_pps_ff;
  logic [23:0] lol_tmr_ff [3];
  logic [15:0] pps_run_ff;
  logic        ref_edge;
  logic [23:0] prec_ref_cnt_ff;
  logic [15:0] fast_ref_cnt_ff;
  logic        prec_end;
  logic        fast_end;
  logic [2:0]  clr_met;
  logic        pps_trig_met;
  logic        pps_clr_met;
  logic        pps_mode;
  logic [12:0] int_src;
  logic [31:0] rd_val;
  zero_ppm_src_t ref_sel;

  assign pps_mode = ctrl_ff[`CTRL_PPS_MODE];
  assign ref_sel  = zero_ppm_src_t'(ctrl_ff[`CTRL_REF_SEL_LSB +: 3]);

  // two-stage synchronisers; order general_clock_inputs, external reference, crystal
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
      prev_ff  <= 5'h00;
    end else begin
      sync1_ff <= {crystal_input_pair, external_reference_input, general_clock_inputs};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end
  assign edge_seen = sync2_ff & ~prev_ff;

  // configuration registers written by software
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff         <= `CTRL_RST;
      oof_window_ff   <= `OOF_WINDOW_RST;
      oof_hyst_ff     <= `OOF_HYST_RST;
      prec_gate_ff    <= `PREC_GATE_RST;
      prec_nom_ff     <= `PREC_NOM_RST;
      fast_gate_ff    <= `FAST_GATE_RST;
      fast_nom_ff     <= `FAST_NOM_RST;
      lol_delay_ff    <= `LOL_DELAY_RST;
      pps_trig_thr_ff <= `PPS_TRIG_THR_RST;
      pps_clr_thr_ff  <= `PPS_CLR_THR_RST;
      pps_trig_cnt_ff <= `PPS_CNT_RST;
      pps_clr_cnt_ff  <= `PPS_CNT_RST;
      int_mask_ff     <= 13'h0000;
      for (int i = 0; i < 5; i++) los_limit_ff[i] <= `LOS_LIMIT_RST;
      for (int l = 0; l < 3; l++) begin
        lol_set_ff[l] <= `LOL_SET_RST;
        lol_clr_ff[l] <= `LOL_CLR_RST;
      end
    end else if (req.wr) begin
      unique case (req.addr)
        `REG_CTRL:         ctrl_ff         <= req.wdata[11:0];
        `REG_OOF_WINDOW:   oof_window_ff   <= req.wdata[12:0];
        `REG_OOF_HYST:     oof_hyst_ff     <= req.wdata[12:0];
        `REG_PREC_GATE:    prec_gate_ff    <= req.wdata[23:0];
        `REG_PREC_NOM:     prec_nom_ff     <= req.wdata[23:0];
        `REG_FAST_GATE:    fast_gate_ff    <= req.wdata[15:0];
        `REG_FAST_NOM:     fast_nom_ff     <= req.wdata[15:0];
        `REG_LOL_DELAY:    lol_delay_ff    <= req.wdata[23:0];
        `REG_PPS_TRIG_THR: pps_trig_thr_ff <= req.wdata[15:0];
        `REG_PPS_CLR_THR:  pps_clr_thr_ff  <= req.wdata[15:0];
        `REG_PPS_TRIG_CNT: pps_trig_cnt_ff <= req.wdata[15:0];
        `REG_PPS_CLR_CNT:  pps_clr_cnt_ff  <= req.wdata[15:0];
        `REG_INT_MASK:     int_mask_ff     <= req.wdata[12:0];
        default: begin
          for (int i = 0; i < 5; i++)
            if (req.addr == 8'(`REG_LOS_LIMIT0 + 4 * i)) los_limit_ff[i] <= req.wdata[15:0];
          for (int l = 0; l < 3; l++) begin
            if (req.addr == 8'(`REG_LOL_SET0 + 4 * l)) lol_set_ff[l] <= req.wdata[16:0];
            if (req.addr == 8'(`REG_LOL_CLR0 + 4 * l)) lol_clr_ff[l] <= req.wdata[16:0];
          end
        end
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (req.addr)
      `REG_CTRL:         rd_val = {20'h00000, ctrl_ff};
      `REG_OOF_WINDOW:   rd_val = {19'h00000, oof_window_ff};
      `REG_OOF_HYST:     rd_val = {19'h00000, oof_hyst_ff};
      `REG_PREC_GATE:    rd_val = {8'h00, prec_gate_ff};
      `REG_PREC_NOM:     rd_val = {8'h00, prec_nom_ff};
      `REG_FAST_GATE:    rd_val = {16'h0000, fast_gate_ff};
      `REG_FAST_NOM:     rd_val = {16'h0000, fast_nom_ff};
      `REG_LOL_DELAY:    rd_val = {8'h00, lol_delay_ff};
      `REG_PPS_TRIG_THR: rd_val = {16'h0000, pps_trig_thr_ff};
      `REG_PPS_CLR_THR:  rd_val = {16'h0000, pps_clr_thr_ff};
      `REG_PPS_TRIG_CNT: rd_val = {16'h0000, pps_trig_cnt_ff};
      `REG_PPS_CLR_CNT:  rd_val = {16'h0000, pps_clr_cnt_ff};
      `REG_INT_MASK:     rd_val = {19'h00000, int_mask_ff};
      `REG_LIVE:         rd_val = {19'h00000, live};
      `REG_STICKY:       rd_val = {19'h00000, sticky_ff};
      default: begin
        for (int i = 0; i < 5; i++)
          if (req.addr == 8'(`REG_LOS_LIMIT0 + 4 * i)) rd_val = {16'h0000, los_limit_ff[i]};
        for (int l = 0; l < 3; l++) begin
          if (req.addr == 8'(`REG_LOL_SET0 + 4 * l)) rd_val = {15'h0000, lol_set_ff[l]};
          if (req.addr == 8'(`REG_LOL_CLR0 + 4 * l)) rd_val = {15'h0000, lol_clr_ff[l]};
        end
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rdata <= 32'h0000_0000;
    else     rdata <= req.rd ? rd_val : 32'h0000_0000;
  end

  // period timers; a limit above three nominal periods rides through gapped clocks
  for (genvar i = 0; i < 5; i++) begin : g_los
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        per_cnt_ff[i] <= 16'h0000;
        los_ff[i]     <= 1'b0;
      end else begin
        if (edge_seen[i]) per_cnt_ff[i] <= 16'h0000;
        else if (per_cnt_ff[i] != 16'hFFFF) per_cnt_ff[i] <= per_cnt_ff[i] + 16'h0001;
        los_ff[i] <= !ctrl_ff[`CTRL_LOS_DIS_LSB + i] && !edge_seen[i] &&
                     per_cnt_ff[i] >= los_limit_ff[i];
      end
    end
  end

  // zero-ppm reference edge picked by configuration
  always_comb begin
    unique case (ref_sel)
      REF_EXTERNAL: ref_edge = edge_seen[3];
      REF_IN0:      ref_edge = edge_seen[0];
      REF_IN1:      ref_edge = edge_seen[1];
      REF_IN2:      ref_edge = edge_seen[2];
      REF_CRYSTAL:  ref_edge = edge_seen[4];
      default:      ref_edge = edge_seen[3];
    endcase
  end

  // gate counters counted in reference edges
  assign prec_end = ref_edge && (prec_ref_cnt_ff + 24'h000001 >= prec_gate_ff);
  assign fast_end = ref_edge && (fast_ref_cnt_ff + 16'h0001 >= fast_gate_ff);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prec_ref_cnt_ff <= 24'h000000;
      fast_ref_cnt_ff <= 16'h0000;
    end else begin
      if (prec_end) prec_ref_cnt_ff <= 24'h000000;
      else if (ref_edge) prec_ref_cnt_ff <= prec_ref_cnt_ff + 24'h000001;
      if (fast_end) fast_ref_cnt_ff <= 16'h0000;
      else if (ref_edge) fast_ref_cnt_ff <= fast_ref_cnt_ff + 16'h0001;
    end
  end

  // per-channel frequency monitors: general_clock_inputs and external reference
  for (genvar c = 0; c < 4; c++) begin : g_oof
    logic [23:0] prec_cnt_ff;
    logic [15:0] fast_cnt_ff;
    logic [23:0] prec_dev;
    logic [15:0] fast_dev;
    logic [23:0] win;
    logic [23:0] low;
    assign prec_dev = (prec_cnt_ff > prec_nom_ff) ? prec_cnt_ff - prec_nom_ff : prec_nom_ff - prec_cnt_ff;
    assign fast_dev = (fast_cnt_ff > fast_nom_ff) ? fast_cnt_ff - fast_nom_ff : fast_nom_ff - fast_cnt_ff;
    assign win      = {11'h000, oof_window_ff};
    // deassert boundary saturates at zero when hysteresis exceeds the window
    assign low      = (oof_hyst_ff > oof_window_ff) ? 24'h000000 : {11'h000, oof_window_ff - oof_hyst_ff};
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        prec_cnt_ff    <= 24'h000000;
        fast_cnt_ff    <= 16'h0000;
        prec_oof_ff[c] <= 1'b0;
        fast_oof_ff[c] <= 1'b0;
      end else begin
        prec_cnt_ff <= prec_end ? {23'h000000, edge_seen[c]} : prec_cnt_ff + {23'h000000, edge_seen[c]};
        fast_cnt_ff <= fast_end ? {15'h0000, edge_seen[c]} : fast_cnt_ff + {15'h0000, edge_seen[c]};
        if (prec_end) begin
          if (prec_dev > win) prec_oof_ff[c] <= 1'b1;
          else if (prec_dev <= low) prec_oof_ff[c] <= 1'b0;
        end
        // one count in nominal/250 is 4000 ppm
        if (fast_end) fast_oof_ff[c] <= ({8'h00, fast_dev} * `FAST_PPM_DIV) > {8'h00, fast_nom_ff};
      end
    end
  end

  // live status word
  always_comb begin
    live.signal_loss_flag = los_ff;
    for (int c = 0; c < 4; c++)
      live.frequency_out_of_range_flag[c] = !pps_mode && ((prec_oof_ff[c] && !ctrl_ff[`CTRL_PREC_DIS]) ||
                                  (fast_oof_ff[c] && !ctrl_ff[`CTRL_FAST_DIS]));
    live.lol_std = lol_std_ff;
    live.lol_pps = lol_pps_ff;
  end

  // standard-mode lock monitors, one per loop
  for (genvar l = 0; l < 3; l++) begin : g_lol
    assign clr_met[l] = loop_report[l].freq_err < lol_clr_ff[l];
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        lol_std_ff[l] <= 1'b1;
        lol_tmr_ff[l] <= 24'h000000;
      end else if (loop_report[l].switched || loop_report[l].freq_err > lol_set_ff[l]) begin
        lol_std_ff[l] <= 1'b1;
        lol_tmr_ff[l] <= 24'h000000;
      end else if (lol_std_ff[l] && clr_met[l]) begin
        if (lol_tmr_ff[l] >= lol_delay_ff) lol_std_ff[l] <= 1'b0;
        else lol_tmr_ff[l] <= lol_tmr_ff[l] + 24'h000001;
      end else begin
        lol_tmr_ff[l] <= 24'h000000; // restart the delay if the clear condition drops
      end
    end
  end

  // pps lock monitor on loop d, counting consecutive cycles past a phase threshold
  assign pps_trig_met = pps_phase_err > pps_trig_thr_ff;
  assign pps_clr_met  = pps_phase_err < pps_clr_thr_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lol_pps_ff <= 1'b1;
      pps_run_ff <= 16'h0000;
    end else if (!pps_mode) begin
      lol_pps_ff <= 1'b0;
      pps_run_ff <= 16'h0000;
    end else if (lol_pps_ff ? pps_clr_met : pps_trig_met) begin
      if (pps_run_ff + 16'h0001 >= (lol_pps_ff ? pps_clr_cnt_ff : pps_trig_cnt_ff)) begin
        lol_pps_ff <= !lol_pps_ff;
        pps_run_ff <= 16'h0000;
      end else begin
        pps_run_ff <= pps_run_ff + 16'h0001;
      end
    end else begin
      pps_run_ff <= 16'h0000;
    end
  end

  // sticky status, write one to clear; a new event in the clear cycle survives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) sticky_ff <= status_t'(13'h0000);
    else sticky_ff <= (sticky_ff & ~((req.wr && req.addr == `REG_STICKY) ? req.wdata[12:0] : 13'h0000))
                      | live;
  end

  // interrupt sources; loop d reports nothing here in pps mode
  assign int_src = sticky_ff & int_mask_ff & ~(pps_mode ? `STATUS_PPS_MASK : 13'h0000);

  // registered pins and qualifiers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_lost_pin_loop_a <= 1'b0;
      lock_lost_pin_loop_c <= 1'b0;
      lock_lost_pin_loop_d <= 1'b0;
      lock_lost_pin_n      <= 1'b1;
      interrupt_pin_n      <= 1'b1;
      outputs_enable       <= 1'b0;
      input_usable         <= 3'h0;
    end else begin
      lock_lost_pin_loop_a <= !lol_std_ff[0];
      lock_lost_pin_loop_c <= !lol_std_ff[1];
      lock_lost_pin_loop_d <= pps_mode ? !lol_pps_ff : !lol_std_ff[2];
      lock_lost_pin_n      <= !(los_ff[3] || live.frequency_out_of_range_flag[3]);
      interrupt_pin_n      <= !(|int_src);
      // outputs run blind through a crystal fault only when software asks
      outputs_enable       <= !(los_ff[4] && !ctrl_ff[`CTRL_KEEP_OUT]);
      input_usable         <= ~(los_ff[2:0] | live.frequency_out_of_range_flag[2:0]);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_switch;
    loop_report[0].switched;
  endsequence
  sequence s_held_lost;
    lol_std_ff[0] ##1 !lock_lost_pin_loop_a;
  endsequence

  sticky_set_wins_a: assert property (live != 13'h0000 |=> (sticky_ff & $past(live)) == $past(live))
    else $error("sticky bit missed a live event");
  edge_clears_los_a: assert property (edge_seen[0] |=> !los_ff[0])
    else $error("signal loss set despite edge");
  los_disable_a: assert property (ctrl_ff[`CTRL_LOS_DIS_LSB + 1] |=> !los_ff[1])
    else $error("disabled loss monitor asserted");
  crystal_outputs_a: assert property (los_ff[4] && !ctrl_ff[`CTRL_KEEP_OUT] |=> !outputs_enable)
    else $error("outputs left on during crystal loss");
  switch_lock_loss_a: assert property (s_switch |=> s_held_lost)
    else $error("input switch did not raise lock loss");
  lol_clear_cause_a: assert property ($fell(lol_std_ff[1]) |-> $past(clr_met[1]) && !$past(lol_tmr_ff[1] < lol_delay_ff))
    else $error("lock loss cleared early");
  pps_change_cause_a: assert property ($rose(lol_pps_ff) |-> $past(pps_trig_met))
    else $error("pps lock loss without trigger");
  interrupt_pin_a: assert property (int_src != 13'h0000 |=> !interrupt_pin_n)
    else $error("interrupt pin not asserted");
  fast_disable_a: assert property (ctrl_ff[`CTRL_FAST_DIS] && ctrl_ff[`CTRL_PREC_DIS] |-> live.frequency_out_of_range_flag == 4'h0)
    else $error("disabled frequency monitors flagged");
  usable_input_a: assert property (los_ff[1] |=> !input_usable[1])
    else $error("faulty input offered for selection");
endmodule // clock_input_fault_monitor

// ### test/clock_input_fault_monitor_test.sv
// self-checking bench for the clock input fault monitor
`timescale 1ns/100ps
`include "clock_fault_regs.svh"
module clock_input_fault_monitor_test;
  import clock_fault_pkg::*;
  typedef struct {
    logic [7:0]  addr;
    logic [31:0] exp;
  } row_t;
  logic         clk;
  logic         rst;
  reg_req_t     req;
  logic [31:0]  rdata;
  logic [4:0]   src;
  logic [4:0]   run;
  logic         gap;
  logic         fast0;
  loop_report_t lr [3];
  logic [15:0]  pps_err;
  logic [2:0]   lock_pin;
  logic         ref_pin_n;
  logic         int_n;
  logic         out_en;
  logic [2:0]   usable;
  logic [31:0]  d;
  int           err_count;
  int           checked;
  // reset value of fifteen registers; the last row is unmapped
  row_t rows [16] = '{'{`REG_CTRL, 32'h0}, '{`REG_LOS_LIMIT0, `LOS_LIMIT_RST}, '{`REG_OOF_WINDOW, `OOF_WINDOW_RST},
    '{`REG_OOF_HYST, `OOF_HYST_RST}, '{`REG_PREC_GATE, `PREC_GATE_RST}, '{`REG_PREC_NOM, `PREC_NOM_RST},
    '{`REG_FAST_GATE, `FAST_GATE_RST}, '{`REG_FAST_NOM, `FAST_NOM_RST}, '{`REG_LOL_SET0, `LOL_SET_RST},
    '{`REG_LOL_CLR0, `LOL_CLR_RST}, '{`REG_LOL_DELAY, 32'h0}, '{`REG_PPS_TRIG_THR, `PPS_TRIG_THR_RST},
    '{`REG_PPS_CLR_THR, `PPS_CLR_THR_RST}, '{`REG_PPS_TRIG_CNT, `PPS_CNT_RST}, '{`REG_INT_MASK, 32'h0},
    '{8'hFC, 32'h0}};

  clock_source_model #(.HALF(5)) src_model (.clk(clk), .rst(rst), .run(run), .gap(gap), .fast0(fast0), .clk_out(src));

  clock_input_fault_monitor uut (
    .clk(clk), .rst(rst), .req(req), .rdata(rdata), .general_clock_inputs(src[2:0]),
    .external_reference_input(src[3]), .crystal_input_pair(src[4]), .loop_report(lr),
    .pps_phase_err(pps_err), .lock_lost_pin_loop_a(lock_pin[0]), .lock_lost_pin_loop_c(lock_pin[1]),
    .lock_lost_pin_loop_d(lock_pin[2]), .lock_lost_pin_n(ref_pin_n), .interrupt_pin_n(int_n),
    .outputs_enable(out_en), .input_usable(usable));

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk) req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk) req.wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk) req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk) req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // bounded poll of one live status bit; running out ends the run
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      rd(`REG_LIVE);
      n++;
    end while (d[b] !== v && n < 200);
    chk("live bit", 32'(d[b]), 32'(v));
    if (d[b] !== v) close_out;
  endtask

  task automatic set_err(input logic [16:0] e);
    @(posedge clk);
    for (int i = 0; i < 3; i++) lr[i] <= '{switched: 1'b0, freq_err: e};
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    close_out;
  end

  initial begin
    rst = 1'b1; req = '0; run = 5'h1F; gap = 1'b0; fast0 = 1'b0; pps_err = 16'h0;
    err_count = 0; checked = 0;
    for (int i = 0; i < 3; i++) lr[i] = '{switched: 1'b0, freq_err: 17'h00005};
    repeat (11) @(posedge clk);
    #1 chk("pins in reset", {lock_pin, ref_pin_n, int_n, out_en, usable, rdata[0]}, 10'b000_1_1_0_000_0);
    @(posedge clk) rst <= 1'b0;
    foreach (rows[i]) begin
      rd(rows[i].addr);
      chk("reset value", d, rows[i].exp);
    end
    // error between clear and set thresholds keeps the reset lock loss
    edges(2); chk("lock pins", lock_pin, 3'h0);
    set_err(17'h0); edges(1); chk("lock pins", lock_pin, 3'h0);
    edges(1); chk("lock pins", lock_pin, 3'h7);
    set_err(17'h0000A); edges(3); chk("lock pins", lock_pin, 3'h7);
    set_err(17'h0000B); edges(2); chk("lock pins", lock_pin, 3'h0);
    // clear delay of four cycles
    wr(`REG_LOL_DELAY, 32'h4); set_err(17'h0); edges(5); chk("lock pins", lock_pin, 3'h0);
    edges(1); chk("lock pins", lock_pin, 3'h7);
    wr(`REG_LOL_DELAY, 32'h0);
    @(posedge clk) lr[0].switched <= 1'b1;
    @(posedge clk) lr[0].switched <= 1'b0;
    edges(1); chk("switch pin", lock_pin[0], 1'b0);
    // sticky lock loss from reset drives the masked interrupt
    wr(`REG_INT_MASK, 32'h200); edges(2); chk("interrupt", int_n, 1'b0);
    rd(`REG_STICKY); chk("sticky lol", d[11:9], 3'h7);
    wr(`REG_STICKY, 32'h200); edges(2); chk("interrupt", int_n, 1'b1);
    rd(`REG_STICKY); chk("sticky lol a", d[9], 1'b0);
    // clear while loop a is still out of lock: set must win
    @(posedge clk) lr[0].freq_err <= 17'h0000B;
    wr(`REG_STICKY, 32'h200); rd(`REG_STICKY); chk("sticky set wins", d[9], 1'b1);
    chk("interrupt", int_n, 1'b0);
    set_err(17'h0);
    for (int i = 0; i < 5; i++) wr(8'(`REG_LOS_LIMIT0 + 4 * i), 32'h20);
    // stop each source in turn, then restart it
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) run[i] <= 1'b0;
      poll(i, 1'b1);
      edges(2);
      chk("usable", usable, 3'h7 & ~(3'h1 << i));
      chk("ref pin", ref_pin_n, i != 3);
      chk("out enable", out_en, i != 4);
      @(posedge clk) run[i] <= 1'b1;
      poll(i, 1'b0);
      rd(`REG_STICKY); chk("sticky los", d[i], 1'b1);
    end
    // keep outputs running on crystal loss
    @(posedge clk) run[4] <= 1'b0;
    poll(4, 1'b1);
    wr(`REG_CTRL, 32'h80); edges(2); chk("out enable kept", out_en, 1'b1);
    wr(`REG_CTRL, 32'h0); edges(2); chk("out enable", out_en, 1'b0);
    @(posedge clk) run[4] <= 1'b1;
    poll(4, 1'b0);
    // a disabled monitor reports nothing
    wr(`REG_CTRL, 32'h2);
    @(posedge clk) run[1] <= 1'b0;
    edges(80); rd(`REG_LIVE); chk("disabled los", d[1], 1'b0);
    @(posedge clk) run[1] <= 1'b1;
    wr(`REG_CTRL, 32'h0);
    // gapped in0 must not count as lost
    wr(`REG_STICKY, 32'h1F);
    @(posedge clk) gap <= 1'b1;
    edges(400); rd(`REG_STICKY); chk("gapped los", d[0], 1'b0);
    @(posedge clk) gap <= 1'b0;
    // fast monitor against the crystal as zero-ppm source
    wr(`REG_FAST_GATE, 32'h10); wr(`REG_FAST_NOM, 32'h10);
    wr(`REG_CTRL, 32'h420);
    @(posedge clk) fast0 <= 1'b1;
    poll(5, 1'b1);
    edges(2); chk("usable in0", usable[0], 1'b0);
    wr(`REG_CTRL, 32'h460); edges(4); rd(`REG_LIVE); chk("oof disabled", d[5], 1'b0);
    // precise monitor alone over 16 crystal edges: window 4, deassert at 2 or less
    wr(`REG_PREC_GATE, 32'h10); wr(`REG_PREC_NOM, 32'h10); wr(`REG_OOF_WINDOW, 32'h4); wr(`REG_OOF_HYST, 32'h2);
    wr(`REG_CTRL, 32'h440);
    poll(5, 1'b1);
    @(posedge clk) fast0 <= 1'b0;
    poll(5, 1'b0);
    // loop d in pps mode follows the phase detector
    wr(`REG_PPS_TRIG_CNT, 32'h2); wr(`REG_CTRL, 32'h860);
    @(posedge clk) pps_err <= 16'h0200;
    poll(12, 1'b1);
    edges(2); chk("pps pins", lock_pin, 3'h3);
    @(posedge clk) pps_err <= 16'h0000;
    poll(12, 1'b0);
    close_out;
  end
endmodule // clock_input_fault_monitor_test

// ### test/clock_source_model.sv
// model of the monitored clock sources, derived from the bench clock
`timescale 1ns/100ps
module clock_source_model #(
  parameter int HALF = 5
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [4:0] run,
  input  wire logic       gap,
  input  wire logic       fast0,
  output logic [4:0]      clk_out
);
  logic [3:0] slow_cnt_ff;
  logic [1:0] fast_cnt_ff;
  logic       slow_ff;
  logic       fast_ff;
  logic [2:0] cyc_ff;

  // one slow source feeds every line, a faster one can replace in0
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slow_cnt_ff <= 4'h0;
      fast_cnt_ff <= 2'h0;
      slow_ff     <= 1'b0;
      fast_ff     <= 1'b0;
      cyc_ff      <= 3'h0;
    end else begin
      slow_cnt_ff <= (slow_cnt_ff == 4'(HALF - 1)) ? 4'h0 : slow_cnt_ff + 4'h1;
      fast_cnt_ff <= (fast_cnt_ff == 2'h2) ? 2'h0 : fast_cnt_ff + 2'h1;
      if (fast_cnt_ff == 2'h2) fast_ff <= ~fast_ff;
      if (slow_cnt_ff == 4'(HALF - 1)) begin
        slow_ff <= ~slow_ff;
        if (!slow_ff) cyc_ff <= cyc_ff + 3'h1;
      end
    end
  end

  // a stopped line rests low; gapping drops two pulses of every eight
  assign clk_out[0]   = run[0] & (fast0 ? fast_ff : slow_ff & ~(gap & (cyc_ff >= 3'h6)));
  assign clk_out[4:1] = run[4:1] & {4{slow_ff}};
endmodule // clock_source_model
